// ### rtl/audio_rx_pkg.sv
package audio_rx_pkg;

    // Bus geometry
    localparam int APB_ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte addresses
    localparam logic [APB_ADDR_W-1:0] ADDR_BIT_MASK = 8'h00;
    localparam logic [APB_ADDR_W-1:0] ADDR_STREAM_FMT = 8'h04;
    localparam logic [APB_ADDR_W-1:0] ADDR_STATUS = 8'h08;
    localparam logic [APB_ADDR_W-1:0] ADDR_WORD_BUF = 8'h0c;

    // Reset values
    localparam logic [DATA_W-1:0] BIT_MASK_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] STREAM_FMT_RST = 32'h0000_0000;

    // Format register layout; bits above the delay field are reserved
    localparam logic [DATA_W-1:0] FMT_WRITE_MASK = 32'h0003_ffff;
    localparam int FMT_DELAY_MSB = 17;
    localparam int FMT_DELAY_LSB = 16;
    localparam int FMT_MSB_FIRST = 15;
    localparam int FMT_PAD_MSB = 14;
    localparam int FMT_PAD_LSB = 13;
    localparam int FMT_PBIT_MSB = 12;
    localparam int FMT_PBIT_LSB = 8;
    localparam int FMT_SLOT_MSB = 7;
    localparam int FMT_SLOT_LSB = 4;
    localparam int FMT_ROT_MSB = 2;
    localparam int FMT_ROT_LSB = 0;

    // Status register layout
    localparam int STAT_READY = 0;
    localparam int STAT_OVERRUN = 1;

    // Pad select codes
    localparam logic [1:0] PAD_ZERO = 2'h0;
    localparam logic [1:0] PAD_ONE = 2'h1;
    localparam logic [1:0] PAD_BIT = 2'h2;

    // First-bit delay codes
    localparam logic [1:0] DELAY_NONE = 2'h0;
    localparam logic [1:0] DELAY_TWO = 2'h2;
    localparam logic [1:0] DELAY_RSVD = 2'h3;

    // Slot length: legal codes are odd and at least this value
    localparam logic [3:0] SLOT_CODE_MIN = 4'h3;
    localparam logic [5:0] SLOT_LEN_MAX = 6'h20;
    localparam logic [5:0] SLOT_LEN_BASE = 6'h02;

    // Capture state machine, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DELAY = 3'b010,
        ST_SHIFT = 3'b100
    } cap_state_e;

endpackage : audio_rx_pkg

// ### rtl/rx_format_if.sv
`timescale 1ns/100ps
interface rx_format_if;
    logic [31:0] raw;
    logic [31:0] mask;
    logic msb_first;
    logic [2:0] rot;
    logic [1:0] pad_sel;
    logic [4:0] pad_bit;
    logic [31:0] rotated;
    logic [31:0] result;

    modport ctrl (output raw, mask, msb_first, rot, pad_sel, pad_bit, input rotated, result);
    modport unit (input raw, mask, msb_first, rot, pad_sel, pad_bit, output rotated, result);
endinterface : rx_format_if

// ### rtl/rx_format_unit.sv
`timescale 1ns/100ps
module rx_format_unit (
    rx_format_if.unit f
);
    import audio_rx_pkg::*;

    logic [31:0] reversed;
    logic [63:0] doubled;
    logic [4:0] shift_amt;
    logic pad_val;

    // Bit reversal for a most-significant-first stream
    for (genvar i = 0; i < 32; i++) begin : g_rev
        assign reversed[i] = f.msb_first ? f.raw[31-i] : f.raw[i];
    end

    // Rotate right by four positions per step
    assign shift_amt = {f.rot, 2'b00};
    assign doubled = {reversed, reversed} >> shift_amt;
    assign f.rotated = doubled[31:0];

    // Pad value; the source bit is taken before masking
    always_comb begin
        case (f.pad_sel)
            PAD_ZERO: pad_val = 1'b0;
            PAD_ONE: pad_val = 1'b1;
            PAD_BIT: pad_val = f.rotated[f.pad_bit];
            default: pad_val = 1'b0;
        endcase
    end

    // Mask stage after reverse and rotate
    for (genvar i = 0; i < 32; i++) begin : g_mask
        assign f.result[i] = f.mask[i] ? f.rotated[i] : pad_val;
    end

endmodule : rx_format_unit

// ### rtl/rx_slot_capture.sv
`timescale 1ns/100ps
module rx_slot_capture (
    input wire logic rx_bit_clock_in,
    input wire logic rst_n_in,
    input wire logic rx_frame_sync_in,
    input wire logic serial_data_pin_in,
    input wire logic [1:0] delay_cfg_in,
    input wire logic [3:0] slot_code_in,
    output logic [31:0] word_out,
    output logic word_toggle_out
);
    import audio_rx_pkg::*;

    typedef struct packed {
        logic [1:0] rst_pipe;
        logic [1:0] dly_s1;
        logic [1:0] dly_s2;
        logic [3:0] slot_s1;
        logic [3:0] slot_s2;
        cap_state_e state;
        logic [1:0] wait_cnt;
        logic [5:0] cnt;
        logic [31:0] shift;
        logic [31:0] word;
        logic toggle;
    } cap_s;

    cap_s q_ff;
    cap_s nxt_q;
    logic [1:0] dly;
    logic [5:0] len;
    logic run;
    logic take;
    logic [31:0] shift_w;

    // Effective delay and slot length from synchronised settings
    always_comb begin
        dly = (q_ff.dly_s2 == DELAY_RSVD) ? DELAY_TWO : q_ff.dly_s2;
        if (q_ff.slot_s2[0] && q_ff.slot_s2 >= SLOT_CODE_MIN) begin
            len = {1'b0, q_ff.slot_s2, 1'b0} + SLOT_LEN_BASE;
        end else begin
            len = SLOT_LEN_MAX;
        end
        run = q_ff.rst_pipe[1];
    end

    // Capture sequencer: frame sync restarts, slots follow back to back
    always_comb begin
        nxt_q = q_ff;
        nxt_q.rst_pipe = {q_ff.rst_pipe[0], 1'b1};
        nxt_q.dly_s1 = delay_cfg_in;
        nxt_q.dly_s2 = q_ff.dly_s1;
        nxt_q.slot_s1 = slot_code_in;
        nxt_q.slot_s2 = q_ff.slot_s1;
        take = 1'b0;
        shift_w = q_ff.shift;
        if (!run) begin
            nxt_q.state = ST_IDLE;
            nxt_q.cnt = '0;
        end else if (rx_frame_sync_in) begin
            shift_w = '0;
            nxt_q.cnt = '0;
            if (dly == DELAY_NONE) begin
                take = 1'b1;
                nxt_q.state = ST_SHIFT;
            end else begin
                nxt_q.wait_cnt = dly - 2'h1;
                nxt_q.state = ST_DELAY;
            end
        end else begin
            case (q_ff.state)
                ST_IDLE: nxt_q.state = ST_IDLE;
                ST_DELAY: begin
                    if (q_ff.wait_cnt == 2'h0) begin
                        take = 1'b1;
                        nxt_q.state = ST_SHIFT;
                    end else begin
                        nxt_q.wait_cnt = q_ff.wait_cnt - 2'h1;
                    end
                end
                ST_SHIFT: take = 1'b1;
                default: nxt_q.state = ST_IDLE;
            endcase
        end
        if (take) begin
            shift_w[nxt_q.cnt[4:0]] = serial_data_pin_in;
            if (nxt_q.cnt == len - 6'h01) begin
                nxt_q.word = shift_w;
                nxt_q.toggle = ~q_ff.toggle;
                nxt_q.cnt = '0;
                shift_w = '0;
            end else begin
                nxt_q.cnt = nxt_q.cnt + 6'h01;
            end
        end
        nxt_q.shift = shift_w;
    end

    // State register
    always_ff @(posedge rx_bit_clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q_ff <= '{state: ST_IDLE, default: '0};
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign word_out = q_ff.word;
    assign word_toggle_out = q_ff.toggle;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb_link @(posedge rx_bit_clock_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_sync_one;
        run && rx_frame_sync_in && dly == 2'h1;
    endsequence

    sequence s_sync_two;
        run && rx_frame_sync_in && dly == DELAY_TWO;
    endsequence

    a_zero_delay: assert property (
        run && rx_frame_sync_in && dly == DELAY_NONE && len > 6'h01
        |=> q_ff.cnt == 6'h01 && q_ff.shift[0] == $past(serial_data_pin_in))
        else $error("first bit not taken with frame sync");
    a_one_delay: assert property (s_sync_one ##1 !rx_frame_sync_in
        |=> q_ff.cnt == 6'h01 && q_ff.shift[0] == $past(serial_data_pin_in))
        else $error("one-bit delay misplaced");
    a_two_delay: assert property (
        s_sync_two ##1 !rx_frame_sync_in ##1 !rx_frame_sync_in
        |=> q_ff.cnt == 6'h01 && q_ff.shift[0] == $past(serial_data_pin_in))
        else $error("two-bit delay misplaced");
    a_slot_end: assert property (q_ff.toggle != $past(q_ff.toggle)
        |-> $past(q_ff.cnt) == $past(len) - 6'h01 || $past(len) == 6'h01)
        else $error("slot closed at wrong length");

endmodule : rx_slot_capture

// ### rtl/audio_rx_format_unit.sv
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
// Summary of operation
// - Mask bit one passes the processed received bit to the reader.
// - Mask bit zero drops the received bit and inserts the pad value.
// - Masking happens after bit reversal and then right rotation.
// - Delay field sets first bit 0, 1 or 2 bit clocks after sync.
// - Zero delay captures first bit in the same cycle sync is seen.
// - Order bit zero means least significant first, no reversal.
// - Order bit one means most significant first, whole 32-bit word is reversed.
// - Pad select gives zeros, ones or a chosen word bit.
// - Padding touches only positions whose mask bit is clear.
// - Pad bit field picks which word bit index is copied.
// - Pad bit field matters only when pad select picks a word bit.
// - Reserved format bits 31 to 18 read zero, writes ignored.
// - Rotate field turns the word right by four times its value.
// - Slot code selects 8 to 32 bit slots in steps of four.
module audio_rx_format_unit (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [audio_rx_pkg::APB_ADDR_W-1:0] paddr_in,
    input wire logic [audio_rx_pkg::DATA_W-1:0] pwdata_in,
    output logic [audio_rx_pkg::DATA_W-1:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic rx_bit_clock_in,
    input wire logic rx_frame_sync_in,
    input wire logic serial_data_pin_in,
    output logic [audio_rx_pkg::DATA_W-1:0] rx_word_out,
    output logic rx_word_valid_out
);
    import audio_rx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [31:0] mask;
        logic [31:0] fmt;
        logic [31:0] word;
        logic ready;
        logic overrun;
        logic valid;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic tog_s1;
        logic tog_s2;
        logic tog_seen;
    } sys_s;

    sys_s q_ff;
    sys_s nxt_q;
    logic [31:0] link_word;
    logic link_toggle;
    logic new_word;
    logic setup;
    logic access;
    logic mapped;
    logic [31:0] rd_mux;
    logic [31:0] wmask;

    rx_format_if fmt ();

    ////////////////////////////////////////////////////////////////////////////
    // Link side capture and formatting datapath

    // Serial capture on the bit clock; settings are static while receiving
    rx_slot_capture u_capture (
        .rx_bit_clock_in(rx_bit_clock_in),
        .rst_n_in(rst_n_in),
        .rx_frame_sync_in(rx_frame_sync_in),
        .serial_data_pin_in(serial_data_pin_in),
        .delay_cfg_in(q_ff.fmt[FMT_DELAY_MSB:FMT_DELAY_LSB]),
        .slot_code_in(q_ff.fmt[FMT_SLOT_MSB:FMT_SLOT_LSB]),
        .word_out(link_word),
        .word_toggle_out(link_toggle)
    );

    // Feed the reverse, rotate and mask chain
    assign fmt.raw = link_word;
    assign fmt.mask = q_ff.mask;
    assign fmt.msb_first = q_ff.fmt[FMT_MSB_FIRST];
    assign fmt.rot = q_ff.fmt[FMT_ROT_MSB:FMT_ROT_LSB];
    assign fmt.pad_sel = q_ff.fmt[FMT_PAD_MSB:FMT_PAD_LSB];
    assign fmt.pad_bit = q_ff.fmt[FMT_PBIT_MSB:FMT_PBIT_LSB];

    rx_format_unit u_format (
        .f(fmt.unit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode and read mux

    always_comb begin
        setup = psel_in && !penable_in;
        access = psel_in && penable_in && q_ff.pready;
        mapped = (paddr_in == ADDR_BIT_MASK) || (paddr_in == ADDR_STREAM_FMT)
            || (paddr_in == ADDR_STATUS) || (paddr_in == ADDR_WORD_BUF);
        wmask = FMT_WRITE_MASK;
        case (paddr_in)
            ADDR_BIT_MASK: rd_mux = q_ff.mask;
            ADDR_STREAM_FMT: rd_mux = q_ff.fmt & wmask;
            ADDR_STATUS: begin
                rd_mux = '0;
                rd_mux[STAT_READY] = q_ff.ready;
                rd_mux[STAT_OVERRUN] = q_ff.overrun;
            end
            ADDR_WORD_BUF: rd_mux = q_ff.word;
            default: rd_mux = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_q = q_ff;
        // Toggle crossing from the bit clock domain
        nxt_q.tog_s1 = link_toggle;
        nxt_q.tog_s2 = q_ff.tog_s1;
        nxt_q.tog_seen = q_ff.tog_s2;
        new_word = q_ff.tog_s2 ^ q_ff.tog_seen;

        // Answer one cycle after setup, zero wait states
        nxt_q.pready = setup;
        nxt_q.pslverr = setup && !mapped;
        nxt_q.prdata = setup && !pwrite_in ? rd_mux : '0;

        // Register writes at the completing access edge
        if (access && pwrite_in) begin
            case (paddr_in)
                ADDR_BIT_MASK: nxt_q.mask = pwdata_in;
                ADDR_STREAM_FMT: nxt_q.fmt = pwdata_in & wmask;
                ADDR_STATUS: begin
                    if (pwdata_in[STAT_OVERRUN]) begin
                        nxt_q.overrun = 1'b0;
                    end
                end
                default: nxt_q.overrun = q_ff.overrun;
            endcase
        end

        // Reading the buffer releases it
        if (access && !pwrite_in && paddr_in == ADDR_WORD_BUF) begin
            nxt_q.ready = 1'b0;
        end

        // New slot: formatted word lands in the buffer; set beats clear
        nxt_q.valid = new_word;
        if (new_word) begin
            nxt_q.word = fmt.result;
            nxt_q.ready = 1'b1;
            if (q_ff.ready) begin
                nxt_q.overrun = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q_ff <= '{mask: BIT_MASK_RST, fmt: STREAM_FMT_RST, default: '0};
        end else begin
            q_ff <= nxt_q;
        end
    end

    // Outputs straight from flops
    assign prdata_out = q_ff.prdata;
    assign pready_out = q_ff.pready;
    assign pslverr_out = q_ff.pslverr;
    assign rx_word_out = q_ff.word;
    assign rx_word_valid_out = q_ff.valid;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [31:0] raw_rev_h;
    logic [63:0] raw_rot_h;
    logic pad_src_h;

    // Independent reference for order and rotation
    always_comb begin
        for (int k = 0; k < 32; k++) begin
            raw_rev_h[k] = fmt.raw[31-k];
        end
        raw_rot_h = {fmt.raw, fmt.raw} >> {fmt.rot, 2'b00};
        pad_src_h = fmt.rotated[fmt.pad_bit];
    end

    default clocking cb_sys @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_fmt_read;
        psel_in && !penable_in && !pwrite_in && paddr_in == ADDR_STREAM_FMT;
    endsequence

    a_keep_unmasked: assert property (q_ff.valid
        |-> ((q_ff.word ^ $past(fmt.rotated)) & $past(q_ff.mask)) == '0)
        else $error("unmasked bit altered");
    a_pad_zero: assert property (q_ff.valid && $past(fmt.pad_sel) == PAD_ZERO
        |-> (q_ff.word & ~$past(q_ff.mask)) == '0)
        else $error("zero padding wrong");
    a_pad_one: assert property (q_ff.valid && $past(fmt.pad_sel) == PAD_ONE
        |-> (q_ff.word | $past(q_ff.mask)) == '1)
        else $error("one padding wrong");
    a_pad_bit: assert property (q_ff.valid && $past(fmt.pad_sel) == PAD_BIT
        |-> (q_ff.word & ~$past(q_ff.mask))
            == ($past(pad_src_h) ? ~$past(q_ff.mask) : '0))
        else $error("word-bit padding wrong");
    a_lsb_order: assert property (q_ff.valid && !$past(fmt.msb_first)
        |-> ((q_ff.word ^ $past(raw_rot_h[31:0])) & $past(q_ff.mask)) == '0)
        else $error("lsb-first word wrong");
    a_msb_order: assert property (q_ff.valid && $past(fmt.msb_first)
        && $past(fmt.rot) == 3'h0
        |-> ((q_ff.word ^ $past(raw_rev_h)) & $past(q_ff.mask)) == '0)
        else $error("msb-first word not reversed");
    a_same_transfer: assert property (q_ff.tog_s2 != q_ff.tog_seen
        |=> q_ff.valid && q_ff.ready && q_ff.word == $past(fmt.result))
        else $error("buffer not loaded with formatted word");
    a_fmt_reserved: assert property (s_fmt_read
        |=> pready_out && prdata_out[31:18] == '0)
        else $error("reserved format bits not zero");

    // Buffer bookkeeping: an unread word flags overrun, a read frees the buffer
    a_overrun_set: assert property (new_word && q_ff.ready
        |=> q_ff.overrun && q_ff.ready)
        else $error("overwritten word not flagged");
    a_buffer_release: assert property (access && !pwrite_in && paddr_in == ADDR_WORD_BUF
        && !new_word |=> !q_ff.ready)
        else $error("buffer read left word ready");

endmodule : audio_rx_format_unit

// ### test/audio_codec_model.sv
`timescale 1ns/100ps
module audio_codec_model (
    output logic rx_bit_clock_out,
    output logic rx_frame_sync_out,
    output logic serial_data_pin_out
);
    localparam real HALF_NS = 3.0;

    // Clock parked low, data toggling so a stale level never looks valid
    initial begin
        rx_bit_clock_out = 1'b0;
        rx_frame_sync_out = 1'b0;
        serial_data_pin_out = 1'b0;
    end

    // Bit clocks with sync low; data keeps changing each cycle
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            #HALF_NS rx_bit_clock_out = 1'b1;
            #HALF_NS rx_bit_clock_out = 1'b0;
            serial_data_pin_out = ~serial_data_pin_out;
        end
    endtask : idle_clocks

    // One slot, lsb of bits first; changes land while the clock is low
    task automatic send_slot(input logic [31:0] bits, input int len, input int dly);
        idle_clocks(4);
        for (int i = 0; i < len + dly; i++) begin
            rx_frame_sync_out = (i == 0);
            serial_data_pin_out = (i >= dly) ? bits[i - dly] : ~serial_data_pin_out;
            #HALF_NS rx_bit_clock_out = 1'b1;
            #HALF_NS rx_bit_clock_out = 1'b0;
        end
        // Clock stops after the frame; data line shows the inverse
        rx_frame_sync_out = 1'b0;
        serial_data_pin_out = ~serial_data_pin_out;
    endtask : send_slot
endmodule : audio_codec_model

// ### test/audio_rx_format_unit_test.sv
`timescale 1ns/100ps
module audio_rx_format_unit_test;
    import audio_rx_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [APB_ADDR_W-1:0] paddr_in = 8'h00;
    logic [DATA_W-1:0] pwdata_in = 32'h0;
    logic [DATA_W-1:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic rx_bit_clock_in;
    logic rx_frame_sync_in;
    logic serial_data_pin_in;
    logic [DATA_W-1:0] rx_word_out;
    logic rx_word_valid_out;
    int miscompares = 0;
    int checks = 0;

    // System clock, 8 ns
    always #4 clk_sys_in = ~clk_sys_in;

    audio_rx_format_unit uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .rx_bit_clock_in(rx_bit_clock_in), .rx_frame_sync_in(rx_frame_sync_in),
        .serial_data_pin_in(serial_data_pin_in), .rx_word_out(rx_word_out),
        .rx_word_valid_out(rx_word_valid_out));

    audio_codec_model codec (.rx_bit_clock_out(rx_bit_clock_in),
        .rx_frame_sync_out(rx_frame_sync_in), .serial_data_pin_out(serial_data_pin_in));

    ////////////////////////////////////////////////////////////////////////////////
    // Common helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [APB_ADDR_W-1:0] addr,
                       input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_sys_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= wd;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (pready_out !== 1'b1) begin
            miscompares++;
            conclude();
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    task automatic wr(input logic [APB_ADDR_W-1:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb(1'b1, addr, wd, rd, err);
    endtask : wr

    // Mask then format; reserved format bits always written as zero
    task automatic cfg(input logic [1:0] dly, input logic msb, input logic [1:0] pad,
                       input logic [4:0] pbit, input logic [3:0] slot, input logic [2:0] rot,
                       input logic [31:0] mask);
        wr(ADDR_BIT_MASK, mask);
        wr(ADDR_STREAM_FMT, {14'h0, dly, msb, pad, pbit, slot, 1'b0, rot});
    endtask : cfg

    // Reverse, rotate right by 4*rot, then mask and pad
    function automatic logic [31:0] fmt_ref(logic [31:0] raw, logic msb, logic [2:0] rot,
                                            logic [31:0] mask, logic [1:0] pad, logic [4:0] pbit);
        logic [31:0] r;
        logic [63:0] dbl;
        logic pv;
        for (int i = 0; i < 32; i++) r[i] = msb ? raw[31-i] : raw[i];
        dbl = {r, r} >> (4 * rot);
        pv = (pad == PAD_ONE) || (pad == PAD_BIT && dbl[pbit]);
        return (dbl[31:0] & mask) | (~mask & {32{pv}});
    endfunction : fmt_ref

    // Send a slot, wait for the word, compare port and buffer read
    task automatic frame(input logic [31:0] bits, input int len, input int dly,
                         input logic [31:0] exp);
        int n;
        logic [31:0] rd;
        logic err;
        codec.send_slot(bits, len, dly);
        n = 0;
        while (rx_word_valid_out !== 1'b1 && n < 40) begin
            @(posedge clk_sys_in);
            n++;
        end
        if (rx_word_valid_out !== 1'b1) begin
            miscompares++;
            conclude();
        end
        check(rx_word_out, exp);
        apb(1'b0, ADDR_WORD_BUF, 32'h0, rd, err);
        check(rd, exp);
    endtask : frame

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs;
        logic [31:0] rd;
        logic err;
        apb(1'b0, ADDR_BIT_MASK, 32'h0, rd, err);
        check(rd, BIT_MASK_RST);
        apb(1'b0, ADDR_STREAM_FMT, 32'h0, rd, err);
        check(rd, STREAM_FMT_RST);
        wr(ADDR_BIT_MASK, 32'ha5a5_5a5a);
        apb(1'b0, ADDR_BIT_MASK, 32'h0, rd, err);
        check(rd, 32'ha5a5_5a5a);
        wr(ADDR_STREAM_FMT, 32'hffff_ffff);
        apb(1'b0, ADDR_STREAM_FMT, 32'h0, rd, err);
        check(rd, 32'h0003_ffff);
        apb(1'b0, 8'h10, 32'h0, rd, err);
        check(rd, 32'h0);
        check({31'h0, err}, 32'h1);
    endtask : t_regs

    // Delay codes 0 to 3; the reserved code behaves as two
    task automatic t_delay;
        for (int d = 0; d < 4; d++) begin
            cfg(2'(d), 1'b0, PAD_ZERO, 5'h0, 4'hf, 3'h0, 32'hffff_ffff);
            frame(32'hc3a5_0f96 ^ d, 32, (d == 3) ? 2 : d, 32'hc3a5_0f96 ^ d);
        end
    endtask : t_delay

    task automatic t_order_rotate;
        logic [31:0] b;
        for (int m = 0; m < 2; m++) begin
            for (int r = 0; r < 8; r++) begin
                b = 32'h1234_5678 + r;
                cfg(DELAY_NONE, 1'(m), PAD_ZERO, 5'h0, 4'hf, 3'(r), 32'hffff_ffff);
                frame(b, 32, 0, fmt_ref(b, 1'(m), 3'(r), '1, PAD_ZERO, 5'h0));
            end
        end
    endtask : t_order_rotate

    task automatic t_pad;
        logic [1:0] pads [5] = '{PAD_ZERO, PAD_ONE, PAD_BIT, PAD_BIT, 2'h3};
        logic [4:0] pbits [5] = '{5'h1f, 5'h00, 5'h04, 5'h14, 5'h04};
        logic [31:0] b;
        b = 32'h8e5a_c3f0;
        for (int i = 0; i < 5; i++) begin
            cfg(DELAY_NONE, 1'b0, pads[i], pbits[i], 4'hf, 3'h1, 32'h00ff_ff00);
            frame(b, 32, 0, fmt_ref(b, 1'b0, 3'h1, 32'h00ff_ff00, pads[i], pbits[i]));
        end
    endtask : t_pad

    task automatic t_slot;
        int len;
        logic [31:0] m;
        for (int c = 0; c < 16; c++) begin
            len = (c % 2 == 1 && c >= 3) ? 2 * (c + 1) : 32; // Reserved codes give 32 bits
            m = (len == 32) ? 32'hffff_ffff : ((32'h1 << len) - 32'h1);
            cfg(DELAY_NONE, 1'b0, PAD_ZERO, 5'h0, 4'(c), 3'h0, m);
            frame(32'hdb6d_b6db, len, 0, 32'hdb6d_b6db & m);
        end
    endtask : t_slot

    // Unread word overwritten: overrun flagged, write one clears it
    task automatic t_status;
        logic [31:0] rd;
        logic err;
        cfg(DELAY_NONE, 1'b0, PAD_ONE, 5'h0, 4'h3, 3'h0, 32'h0000_00ff);
        codec.send_slot(32'h0000_00c3, 8, 0);
        frame(32'h0000_005a, 8, 0, 32'hffff_ff5a);
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        check(rd, 32'h1 << STAT_OVERRUN);
        wr(ADDR_STATUS, 32'h1 << STAT_OVERRUN);
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        check(rd, 32'h0);
    endtask : t_status

    ////////////////////////////////////////////////////////////////////////////////
    // Reset with the bit clock running, then the scenarios
    initial begin
        fork
            codec.idle_clocks(6);
            repeat (6) @(posedge clk_sys_in);
        join
        rst_n_in <= 1'b1;
        t_regs();
        t_delay();
        t_order_rotate();
        t_pad();
        t_slot();
        t_status();
        conclude();
    end
endmodule : audio_rx_format_unit_test
